/* File: rtl/ets_pkg.sv */
// Package of register offsets, field layouts and phase codes for the capture slots.
package ets_pkg;
  localparam logic [11:0] ETS_SAMPLE4_NANOSECONDS_OFS = 12'h578;
  localparam logic [11:0] ETS_SAMPLE4_SECONDS_OFS = 12'h57C;
  localparam logic [11:0] ETS_SAMPLE4_PHASE_OFS = 12'h580;
  localparam logic [11:0] ETS_SAMPLE5_NANOSECONDS_OFS = 12'h584;
  localparam logic [11:0] ETS_SAMPLE5_SECONDS_OFS = 12'h588;
  localparam logic [11:0] ETS_SAMPLE5_PHASE_OFS = 12'h58C;
  localparam logic [11:0] ETS_SAMPLE6_NANOSECONDS_OFS = 12'h590;
  localparam logic [11:0] ETS_SAMPLE6_SECONDS_OFS = 12'h594;
  localparam logic [11:0] ETS_SAMPLE6_PHASE_OFS = 12'h598;
  localparam logic [11:0] ETS_UNIT_INDEX_OFS = 12'h500;
  localparam int ETS_UNIT_PTR_BIT = 8;
  localparam int ETS_NS_WIDTH = 30;
  localparam int ETS_POLARITY_BIT = 30;
  localparam int ETS_SLICE_WIDTH = 3;
  localparam int ETS_NUM_SLOTS = 3;
  localparam logic [31:0] ETS_SECONDS_RESET = 32'h0000_0000;
  localparam logic [29:0] ETS_NS_RESET = 30'h0000_0000;
  localparam logic [2:0] ETS_SLICE_RESET = 3'h0;
  localparam logic [2:0] ETS_SLICE_0NS = 3'h0;
  localparam logic [2:0] ETS_SLICE_8NS = 3'h1;
  localparam logic [2:0] ETS_SLICE_16NS = 3'h2;
  localparam logic [2:0] ETS_SLICE_24NS = 3'h3;
  localparam logic [2:0] ETS_SLICE_32NS = 3'h4;
  localparam logic [31:0] ETS_UNMAPPED_READ = 32'h0000_0000;
endpackage

/* File: rtl/ets_slice_enc.sv */
// Encoder from an 8 ns slice index of the 40 ns period to the phase code.
`timescale 1ns/1ps
module ets_slice_enc
  import ets_pkg::*;
(
  input wire logic [2:0] slice_idx_i,
  output logic [2:0] slice_code_o
);
  always_comb
  begin
    unique case (slice_idx_i)
      3'h0: slice_code_o = ETS_SLICE_0NS;
      3'h1: slice_code_o = ETS_SLICE_8NS;
      3'h2: slice_code_o = ETS_SLICE_16NS;
      3'h3: slice_code_o = ETS_SLICE_24NS;
      3'h4: slice_code_o = ETS_SLICE_32NS;
      default: slice_code_o = ETS_SLICE_0NS;
    endcase
  end
endmodule // ets_slice_enc

/* File: rtl/ets_sample_slots.sv */
// Capture storage for the fourth to sixth event timestamp samples of each unit.
`timescale 1ns/1ps
module ets_sample_slots
  import ets_pkg::*;
#(
  parameter int NUM_UNITS = 2
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic event_i,
  input wire logic [31:0] time_seconds_i,
  input wire logic [29:0] time_nanoseconds_i,
  input wire logic [2:0] time_slice_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [1:0] capture_count_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic [0:0] unit_ptr;
    logic [NUM_UNITS-1:0][1:0] fill;
    logic [NUM_UNITS-1:0][ETS_NUM_SLOTS-1:0][31:0] seconds;
    logic [NUM_UNITS-1:0][ETS_NUM_SLOTS-1:0][29:0] nanosec;
    logic [NUM_UNITS-1:0][ETS_NUM_SLOTS-1:0] polarity;
    logic [NUM_UNITS-1:0][ETS_NUM_SLOTS-1:0][2:0] slice;
    logic [31:0] rdata;
    logic [1:0] count;
  } ets_state_t;

  ets_state_t state_reg;
  ets_state_t state_next;
  logic [2:0] slice_code;
  logic edge_seen;
  logic edge_rising;
  logic [1:0] cap_slot;
  logic [0:0] cap_unit;

  ets_slice_enc u_enc
  (
    .slice_idx_i(time_slice_i),
    .slice_code_o(slice_code)
  );

  function automatic logic [1:0] slot_of(input logic [11:0] a);
    if (a >= ETS_SAMPLE6_NANOSECONDS_OFS)
    begin
      return 2'h2;
    end
    else if (a >= ETS_SAMPLE5_NANOSECONDS_OFS)
    begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  // True for any of the three nanoseconds words.
  function automatic logic is_ns_ofs(input logic [11:0] a);
    return a == ETS_SAMPLE4_NANOSECONDS_OFS || a == ETS_SAMPLE5_NANOSECONDS_OFS
      || a == ETS_SAMPLE6_NANOSECONDS_OFS;
  endfunction

  // True for any of the three seconds words.
  function automatic logic is_sec_ofs(input logic [11:0] a);
    return a == ETS_SAMPLE4_SECONDS_OFS || a == ETS_SAMPLE5_SECONDS_OFS
      || a == ETS_SAMPLE6_SECONDS_OFS;
  endfunction

  // True for any of the three phase words.
  function automatic logic is_phase_ofs(input logic [11:0] a);
    return a == ETS_SAMPLE4_PHASE_OFS || a == ETS_SAMPLE5_PHASE_OFS
      || a == ETS_SAMPLE6_PHASE_OFS;
  endfunction

  assign edge_seen = state_reg.sync[2] ^ state_reg.sync[1];
  assign edge_rising = state_reg.sync[1];
  assign cap_unit = state_reg.unit_ptr;
  assign cap_slot = state_reg.fill[cap_unit];

  always_comb
  begin
    logic [1:0] s;
    logic [0:0] u;
    s = slot_of(addr_i);
    u = state_reg.unit_ptr;
    state_next = state_reg;
    state_next.sync = {state_reg.sync[1:0], event_i};
    if (wr_i && addr_i == ETS_UNIT_INDEX_OFS)
    begin
      state_next.unit_ptr = wdata_i[ETS_UNIT_PTR_BIT];
    end
    if (edge_seen && cap_slot < 2'(ETS_NUM_SLOTS))
    begin
      state_next.seconds[cap_unit][cap_slot] = time_seconds_i;
      state_next.nanosec[cap_unit][cap_slot] = time_nanoseconds_i;
      state_next.polarity[cap_unit][cap_slot] = edge_rising;
      state_next.slice[cap_unit][cap_slot] = slice_code;
      state_next.fill[cap_unit] = cap_slot + 2'h1;
    end
    state_next.count = state_next.fill[u];
    state_next.rdata = state_reg.rdata;
    if (rd_i)
    begin
      unique case (addr_i)
        ETS_SAMPLE4_NANOSECONDS_OFS, ETS_SAMPLE5_NANOSECONDS_OFS,
        ETS_SAMPLE6_NANOSECONDS_OFS:
          state_next.rdata = {1'b0, state_reg.polarity[u][s],
                              state_reg.nanosec[u][s]};
        ETS_SAMPLE4_SECONDS_OFS, ETS_SAMPLE5_SECONDS_OFS, ETS_SAMPLE6_SECONDS_OFS:
          state_next.rdata = state_reg.seconds[u][s];
        ETS_SAMPLE4_PHASE_OFS, ETS_SAMPLE5_PHASE_OFS, ETS_SAMPLE6_PHASE_OFS:
          state_next.rdata = {29'h0, state_reg.slice[u][s]};
        ETS_UNIT_INDEX_OFS:
          state_next.rdata = {23'h0, state_reg.unit_ptr, 8'h00};
        default:
          state_next.rdata = ETS_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign capture_count_o = state_reg.count;

  AST_NS_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(rd_i) && $past(addr_i) == ETS_SAMPLE5_NANOSECONDS_OFS |-> !rdata_o[31])
    else $error("Reserved nanoseconds bit read as one.");
  AST_PHASE_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(rd_i) && $past(addr_i) == ETS_SAMPLE4_PHASE_OFS |-> rdata_o[31:3] == 29'h0)
    else $error("Reserved phase bits read as nonzero.");
  AST_PHASE_CODE_LEGAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(rd_i) && $past(addr_i) == ETS_SAMPLE6_PHASE_OFS |-> rdata_o[2:0] <= 3'h4)
    else $error("Phase code outside the legal set.");
  AST_POLARITY_CAPTURE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    edge_seen && cap_slot == 2'h0 |=> state_reg.polarity[$past(cap_unit)][0]
      == $past(edge_rising))
    else $error("Edge polarity not recorded.");
  AST_SECONDS_CAPTURE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    edge_seen && cap_slot == 2'h1 |=> state_reg.seconds[$past(cap_unit)][1]
      == $past(time_seconds_i))
    else $error("Seconds not captured.");
  AST_NS_CAPTURE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    edge_seen && cap_slot == 2'h2 |=> state_reg.nanosec[$past(cap_unit)][2]
      == $past(time_nanoseconds_i))
    else $error("Nanoseconds not captured.");
  AST_SECONDS_READ: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ETS_SAMPLE5_SECONDS_OFS |=> rdata_o
      == $past(state_reg.seconds[state_reg.unit_ptr][1]))
    else $error("Seconds read from wrong unit or slot.");
  AST_SLICE_16NS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    time_slice_i == 3'h2 |-> slice_code == 3'h2)
    else $error("16 ns slice code wrong.");

  // Each unit and slot takes a capture only when it is the next free one.
  for (genvar gu = 0; gu < NUM_UNITS; gu++)
  begin : g_unit

    AST_FILL_NO_DECREASE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> state_reg.fill[gu] >= $past(state_reg.fill[gu]))
      else $error("Slot fill level went down.");

    for (genvar gs = 0; gs < ETS_NUM_SLOTS; gs++)
    begin : g_slot

      AST_SLOT_SECONDS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        edge_seen && cap_unit == gu && cap_slot == gs |=>
          state_reg.seconds[gu][gs] == $past(time_seconds_i))
        else $error("Slot seconds not captured.");

      AST_SLOT_NS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        edge_seen && cap_unit == gu && cap_slot == gs |=>
          state_reg.nanosec[gu][gs] == $past(time_nanoseconds_i))
        else $error("Slot nanoseconds not captured.");

      AST_SLOT_POLARITY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        edge_seen && cap_unit == gu && cap_slot == gs |=>
          state_reg.polarity[gu][gs] == $past(state_reg.sync[1]))
        else $error("Slot polarity not captured.");

      AST_SLOT_SLICE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        edge_seen && cap_unit == gu && cap_slot == gs |=>
          state_reg.slice[gu][gs] == $past(slice_code))
        else $error("Slot phase code not captured.");

      AST_SLOT_FILL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        edge_seen && cap_unit == gu && cap_slot == gs |=>
          state_reg.fill[gu] == 2'(gs + 1))
        else $error("Slot fill level not advanced.");

      AST_SLOT_SECONDS_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(edge_seen && cap_unit == gu && cap_slot == gs) |=>
          $stable(state_reg.seconds[gu][gs]))
        else $error("Slot seconds changed without a capture.");

      AST_SLOT_NS_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(edge_seen && cap_unit == gu && cap_slot == gs) |=>
          $stable(state_reg.nanosec[gu][gs]))
        else $error("Slot nanoseconds changed without a capture.");

      AST_SLOT_POLARITY_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(edge_seen && cap_unit == gu && cap_slot == gs) |=>
          $stable(state_reg.polarity[gu][gs]))
        else $error("Slot polarity changed without a capture.");

      AST_SLOT_SLICE_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(edge_seen && cap_unit == gu && cap_slot == gs) |=>
          $stable(state_reg.slice[gu][gs]))
        else $error("Slot phase code changed without a capture.");

      AST_SLOT_SLICE_LEGAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_reg.slice[gu][gs] <= ETS_SLICE_32NS)
        else $error("Stored phase code outside the legal set.");
    end
  end

  // Every word of every slot reads back the selected unit's copy.
  for (genvar gs = 0; gs < ETS_NUM_SLOTS; gs++)
  begin : g_read
    localparam logic [11:0] NS_OFS = ETS_SAMPLE4_NANOSECONDS_OFS + 12'(12 * gs);
    localparam logic [11:0] SEC_OFS = ETS_SAMPLE4_SECONDS_OFS + 12'(12 * gs);
    localparam logic [11:0] PH_OFS = ETS_SAMPLE4_PHASE_OFS + 12'(12 * gs);

    AST_READ_NS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_i && addr_i == NS_OFS |=> rdata_o == {1'b0,
        $past(state_reg.polarity[state_reg.unit_ptr][gs]),
        $past(state_reg.nanosec[state_reg.unit_ptr][gs])})
      else $error("Nanoseconds word read from wrong unit or slot.");

    AST_READ_SEC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_i && addr_i == SEC_OFS |=> rdata_o
        == $past(state_reg.seconds[state_reg.unit_ptr][gs]))
      else $error("Seconds word read from wrong unit or slot.");

    AST_READ_PHASE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_i && addr_i == PH_OFS |=> rdata_o[2:0]
        == $past(state_reg.slice[state_reg.unit_ptr][gs]))
      else $error("Phase word read from wrong unit or slot.");
  end

  // Reserved bits read as zero in every slot.
  AST_ANY_NS_RESERVED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && is_ns_ofs(addr_i) |=> !rdata_o[31])
    else $error("Reserved nanoseconds bit read as one.");

  AST_ANY_PHASE_RESERVED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && is_phase_ofs(addr_i) |=> rdata_o[31:3] == 29'h0)
    else $error("Reserved phase bits read as nonzero.");

  AST_UNMAPPED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && !is_ns_ofs(addr_i) && !is_sec_ofs(addr_i) && !is_phase_ofs(addr_i)
      && addr_i != ETS_UNIT_INDEX_OFS |=> rdata_o == ETS_UNMAPPED_READ)
    else $error("Unmapped address read as nonzero.");

  // The unit pointer follows bit 8 of a write and reads back.
  AST_PTR_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ETS_UNIT_INDEX_OFS |=>
      state_reg.unit_ptr == $past(wdata_i[ETS_UNIT_PTR_BIT]))
    else $error("Unit pointer not written.");

  AST_PTR_READBACK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ETS_UNIT_INDEX_OFS |=>
      rdata_o[ETS_UNIT_PTR_BIT] == $past(state_reg.unit_ptr))
    else $error("Unit pointer read back wrong.");

  // Read data stands until the next read.
  AST_RDATA_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_i |=> $stable(rdata_o))
    else $error("Read data changed without a read.");

  // The fill count follows the selected unit.
  AST_COUNT_UNIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> capture_count_o == state_reg.fill[$past(state_reg.unit_ptr)])
    else $error("Capture count shows the wrong unit.");
endmodule // ets_sample_slots

/* File: sim/ets_event_src.sv */
// Model of the external event pin whose edges are timestamped.
`timescale 1ns/1ps
module ets_event_src
(
  output logic event_o
);
  initial event_o = 1'b0;
  // The pin is asynchronous, so it moves away from the clock edge.
  task automatic drive(input logic lvl);
    #7 event_o = lvl;
  endtask
endmodule // ets_event_src

/* File: sim/ets_sample_slots_tb_top.sv */
// Self-checking bench for the capture slots.
`timescale 1ns/1ps
module ets_sample_slots_tb_top;
  import ets_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ev, wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0] sec = 32'h0, wdata_i = 32'h0, rdata_o;
  logic [29:0] ns = 30'h0;
  logic [2:0] sl = 3'h0;
  logic [11:0] addr_i = 12'h0;
  logic [1:0] cnt;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [2:0] code [5] = '{ETS_SLICE_0NS, ETS_SLICE_8NS, ETS_SLICE_16NS, ETS_SLICE_24NS,
    ETS_SLICE_32NS};
  ets_event_src src_u (.event_o(ev));
  ets_sample_slots #(.NUM_UNITS(2)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .event_i(ev),
    .time_seconds_i(sec), .time_nanoseconds_i(ns), .time_slice_i(sl), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_count_o(cnt));
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, exp);
  endtask
  // Holds the time inputs around one pin edge, then moves them away.
  task automatic cap(input logic p, input logic [31:0] s, input logic [29:0] n, input int i);
    @(posedge mclk_i);
    sec <= s;
    ns <= n;
    sl <= i[2:0];
    src_u.drive(p);
    repeat (8) @(posedge mclk_i);
    sec <= ~s;
    ns <= ~n;
    sl <= 3'h4 - i[2:0];
  endtask
  task automatic slot(input logic [11:0] b, input logic p, input logic [31:0] s,
    input logic [29:0] n, input int i);
    rd(b, {1'b0, p, n});
    rd(b + 12'h4, s);
    rd(b + 12'h8, {29'h0, code[i]});
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 9; k++)
      rd(ETS_SAMPLE4_NANOSECONDS_OFS + 12'(4 * k), 32'h0);
    chk({30'h0, cnt}, 32'h0);
    wr(ETS_SAMPLE5_SECONDS_OFS, 32'hFFFF_FFFF);
    rd(ETS_SAMPLE5_SECONDS_OFS, 32'h0);
    rd(12'h5FC, ETS_UNMAPPED_READ);
    $display("test reset done");
    wr(ETS_UNIT_INDEX_OFS, 32'h0);
    cap(1'b1, 32'h1234_5678, 30'h2AAA_5555, 1);
    cap(1'b0, 32'hFEDC_BA98, 30'h1555_AAAA, 2);
    cap(1'b1, 32'h8000_0001, 30'h3B9A_C9FF, 4);
    cap(1'b0, 32'h0BAD_0BAD, 30'h0000_0001, 3);
    slot(ETS_SAMPLE4_NANOSECONDS_OFS, 1'b1, 32'h1234_5678, 30'h2AAA_5555, 1);
    slot(ETS_SAMPLE5_NANOSECONDS_OFS, 1'b0, 32'hFEDC_BA98, 30'h1555_AAAA, 2);
    slot(ETS_SAMPLE6_NANOSECONDS_OFS, 1'b1, 32'h8000_0001, 30'h3B9A_C9FF, 4);
    chk({30'h0, cnt}, 32'h3);
    $display("test unit 0 done");
    wr(ETS_UNIT_INDEX_OFS, 32'h100);
    rd(ETS_UNIT_INDEX_OFS, 32'h100);
    rd(ETS_SAMPLE4_SECONDS_OFS, 32'h0);
    chk({30'h0, cnt}, 32'h0);
    cap(1'b1, 32'h0000_0002, 30'h0000_0003, 3);
    cap(1'b0, 32'h0000_0004, 30'h0000_0005, 0);
    slot(ETS_SAMPLE4_NANOSECONDS_OFS, 1'b1, 32'h0000_0002, 30'h0000_0003, 3);
    slot(ETS_SAMPLE5_NANOSECONDS_OFS, 1'b0, 32'h0000_0004, 30'h0000_0005, 0);
    chk({30'h0, cnt}, 32'h2);
    wr(ETS_UNIT_INDEX_OFS, 32'h0);
    rd(ETS_SAMPLE5_SECONDS_OFS, 32'hFEDC_BA98);
    $display("test unit 1 done");
    conclude();
  end
endmodule // ets_sample_slots_tb_top
